// File: mac_config_registers.sv
`timescale 1ns/1ns
// Function
// - Mode register resets to 0001h, 15:4 reserved
// - Transmit enable gates frame transmission starts
// - Receive enable gates frame reception starts
// - Flow control enable permits pause frame requests
// - Gigabit indicator always reads one, read-only
// - Feature register resets zero, rewrite when disabled and idle
// - Runt frames blocked unless runt acceptance set
// - Broadcast frames accepted when broadcast acceptance set
// - Multicast via hash filter; else only pause
// - Received pause frames hold off transmitter
// - Crc suppress stops transmitter appending FCS
// - Strip FCS and pad before receive FIFO
// - Pad stripping only for length-type frames
// - Promiscuous mode accepts every destination address
// - Frame length limit resets to 05eeh
// - Frames longer than limit flagged long
// - Gap in bytes, one word clock per two
// - Byte addressed host registers, low address low byte
module mac_config_registers (
    input wire logic ref_clk_i, // Core clock, 25 MHz
    input wire logic reset_n_i, // Synchronous reset, active low
    input wire mac_cfg_pkg::host_req_s host_req_i, // Host byte access request
    output logic [mac_cfg_pkg::HOST_DATA_W-1:0] host_rdata_o, // Read byte
    output logic host_ack_o, // Access done pulse
    output mac_cfg_pkg::mode_s mode_o, // Mode fields
    output mac_cfg_pkg::feature_s feature_o, // Feature control fields
    output logic [15:0] frame_length_limit_o, // Long frame threshold
    input wire logic tx_busy_i, // Transmit frame in progress
    input wire logic rx_busy_i, // Receive frame in progress
    output logic tx_start_ok_o, // New transmit frame may start
    output logic rx_start_ok_o, // New receive frame may start
    output logic mac_idle_o, // Both directions disabled and idle
    output logic tx_fcs_append_o, // Transmitter appends FCS
    input wire logic pause_send_request_i, // Request a pause frame
    input wire logic [15:0] pause_send_quanta_i, // Pause time to send
    output logic tx_pause_send_o, // Pause frame send pulse
    output logic [15:0] tx_pause_quanta_o, // Pause time for sending
    input wire logic rx_pause_rcvd_i, // Pause frame received pulse
    input wire logic [15:0] rx_pause_quanta_i, // Pause time received
    output logic tx_pause_hold_o, // Hold off data frames pulse
    output logic [15:0] tx_hold_quanta_o, // Hold off time
    input wire mac_cfg_pkg::rx_addr_s rx_addr_i, // Destination address class
    output logic rx_addr_accept_o, // Address filter verdict
    input wire logic [15:0] rx_len_type_i, // Length/type field
    output logic rx_strip_fcs_o, // Remove FCS before FIFO
    output logic rx_strip_pad_o, // Remove pad before FIFO
    input wire logic rx_frame_end_i, // Frame end pulse
    input wire logic [15:0] rx_frame_bytes_i, // Byte count at frame end
    output logic rx_long_frame_o, // Last frame exceeded limit
    output logic rx_runt_drop_o, // Last frame must be dropped as runt
    input wire logic tx_gap_start_i, // Start inter-frame gap pulse
    output logic tx_gap_done_o // Gap time has elapsed
);
    import mac_cfg_pkg::*;

    function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] base);
        word_hit = (addr[7:1] == base[7:1]);
    endfunction : word_hit

    logic [15:0] mode_q;
    logic [15:0] feature_q;
    logic [15:0] limit_q;
    logic [15:0] gap_q;
    logic sel_mode_w;
    logic sel_feature_w;
    logic sel_limit_w;
    logic sel_gap_w;
    logic wr_lo_w;
    logic wr_hi_w;
    logic unlocked_w;
    logic tx_idle_w;
    logic rx_idle_w;
    logic [15:0] rd_word_w;
    logic [7:0] rd_byte_w;
    logic accept_w;
    logic [4:0] gap_words_w;
    logic [7:0] host_rdata_r;
    logic host_ack_r;
    logic tx_pause_send_r;
    logic [15:0] tx_pause_quanta_r;
    logic tx_pause_hold_r;
    logic [15:0] tx_hold_quanta_r;
    logic rx_addr_accept_r;
    logic rx_strip_pad_r;
    logic rx_long_frame_r;
    logic rx_runt_drop_r;
    logic [4:0] gap_cnt_r;
    logic [4:0] gap_cnt_nxt;

    // Host decode; odd address is the high byte
    assign sel_mode_w = word_hit(host_req_i.addr, ADDR_MODE);
    assign sel_feature_w = word_hit(host_req_i.addr, ADDR_FEATURE);
    assign sel_limit_w = word_hit(host_req_i.addr, ADDR_LIMIT);
    assign sel_gap_w = word_hit(host_req_i.addr, ADDR_GAP);
    assign wr_lo_w = host_req_i.wr && !host_req_i.addr[0];
    assign wr_hi_w = host_req_i.wr && host_req_i.addr[0];

    // A direction is idle once disabled and its current frame has finished
    assign tx_idle_w = !mode_q[MODE_TX_EN_BIT] && !tx_busy_i;
    assign rx_idle_w = !mode_q[MODE_RX_EN_BIT] && !rx_busy_i;
    // Rewriting filter settings mid-frame would corrupt the verdict, so drop it
    assign unlocked_w = tx_idle_w && rx_idle_w;

    cfg_word_reg #(.RESET_VAL(MODE_RESET), .WMASK(MODE_WMASK)) u_mode (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .wr_lo_i(wr_lo_w && sel_mode_w),
        .wr_hi_i(wr_hi_w && sel_mode_w),
        .wdata_i(host_req_i.wdata),
        .q_o(mode_q)
    );

    cfg_word_reg #(.RESET_VAL(FEATURE_RESET), .WMASK(FEATURE_WMASK)) u_feature (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .wr_lo_i(wr_lo_w && sel_feature_w && unlocked_w),
        .wr_hi_i(wr_hi_w && sel_feature_w && unlocked_w),
        .wdata_i(host_req_i.wdata),
        .q_o(feature_q)
    );

    cfg_word_reg #(.RESET_VAL(LIMIT_RESET), .WMASK(LIMIT_WMASK)) u_limit (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .wr_lo_i(wr_lo_w && sel_limit_w && unlocked_w),
        .wr_hi_i(wr_hi_w && sel_limit_w && unlocked_w),
        .wdata_i(host_req_i.wdata),
        .q_o(limit_q)
    );

    cfg_word_reg #(.RESET_VAL(GAP_RESET), .WMASK(GAP_WMASK)) u_gap (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .wr_lo_i(wr_lo_w && sel_gap_w && unlocked_w),
        .wr_hi_i(wr_hi_w && sel_gap_w && unlocked_w),
        .wdata_i(host_req_i.wdata),
        .q_o(gap_q)
    );

    // Reserved bits hold zero in storage, so they read back as zero
    assign rd_word_w = sel_mode_w ? mode_q :
                       sel_feature_w ? feature_q :
                       sel_limit_w ? limit_q :
                       sel_gap_w ? gap_q : 16'h0000;
    assign rd_byte_w = host_req_i.addr[0] ? rd_word_w[15:8] : rd_word_w[7:0];

    // Address filter: promiscuous wins, then unicast, broadcast and multicast
    assign accept_w = feature_q[FEAT_PRMS_BIT]
        || rx_addr_i.unicast_match
        || (rx_addr_i.broadcast && feature_q[FEAT_BCAST_BIT])
        || (rx_addr_i.multicast && !rx_addr_i.broadcast
            && (rx_addr_i.pause
                || (feature_q[FEAT_MCAST_BIT] && rx_addr_i.hash_hit)));

    // Rounds an odd byte gap up to a whole word clock
    assign gap_words_w = 5'((6'(gap_q[GAP_MSB:0]) + 6'h01) >> 1);
    assign gap_cnt_nxt = tx_gap_start_i ? gap_words_w :
                         (gap_cnt_r != 5'h00) ? gap_cnt_r - 5'h01 : gap_cnt_r;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            host_rdata_r <= 8'h00;
            host_ack_r <= 1'b0;
        end else begin
            host_ack_r <= host_req_i.wr || host_req_i.rd;
            if (host_req_i.rd) begin
                host_rdata_r <= rd_byte_w;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            tx_pause_send_r <= 1'b0;
            tx_pause_quanta_r <= 16'h0000;
        end else begin
            tx_pause_send_r <= pause_send_request_i && mode_q[MODE_FLOW_BIT];
            if (pause_send_request_i && mode_q[MODE_FLOW_BIT]) begin
                tx_pause_quanta_r <= pause_send_quanta_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            tx_pause_hold_r <= 1'b0;
            tx_hold_quanta_r <= 16'h0000;
        end else begin
            tx_pause_hold_r <= rx_pause_rcvd_i && feature_q[FEAT_PAUSE_BIT];
            if (rx_pause_rcvd_i && feature_q[FEAT_PAUSE_BIT]) begin
                tx_hold_quanta_r <= rx_pause_quanta_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rx_addr_accept_r <= 1'b0;
            rx_strip_pad_r <= 1'b0;
        end else begin
            rx_addr_accept_r <= accept_w;
            // Type values above the length range carry no pad to remove
            rx_strip_pad_r <= feature_q[FEAT_STRIP_BIT]
                && (rx_len_type_i <= MAX_LENGTH_FIELD);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rx_long_frame_r <= 1'b0;
            rx_runt_drop_r <= 1'b0;
        end else if (rx_frame_end_i) begin
            rx_long_frame_r <= rx_frame_bytes_i > limit_q;
            rx_runt_drop_r <= !feature_q[FEAT_RUNT_BIT]
                && (rx_frame_bytes_i < MIN_FRAME_BYTES);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            gap_cnt_r <= 5'h00;
        end else begin
            gap_cnt_r <= gap_cnt_nxt;
        end
    end

    assign host_rdata_o = host_rdata_r;
    assign host_ack_o = host_ack_r;
    assign mode_o = mode_q[3:0];
    assign feature_o = {feature_q[8:7], feature_q[4:0]};
    assign frame_length_limit_o = limit_q;
    // Only starts are gated; a frame already running is left to finish
    assign tx_start_ok_o = mode_q[MODE_TX_EN_BIT];
    assign rx_start_ok_o = mode_q[MODE_RX_EN_BIT];
    assign mac_idle_o = unlocked_w;
    assign tx_fcs_append_o = !feature_q[FEAT_NOFCS_BIT];
    assign tx_pause_send_o = tx_pause_send_r;
    assign tx_pause_quanta_o = tx_pause_quanta_r;
    assign tx_pause_hold_o = tx_pause_hold_r;
    assign tx_hold_quanta_o = tx_hold_quanta_r;
    assign rx_addr_accept_o = rx_addr_accept_r;
    assign rx_strip_fcs_o = feature_q[FEAT_STRIP_BIT];
    assign rx_strip_pad_o = rx_strip_pad_r;
    assign rx_long_frame_o = rx_long_frame_r;
    assign rx_runt_drop_o = rx_runt_drop_r;
    assign tx_gap_done_o = (gap_cnt_r == 5'h00);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence seq_locked_feature_write;
        host_req_i.wr && sel_feature_w && !unlocked_w;
    endsequence

    sequence seq_gap12_run;
        (tx_gap_start_i && gap_q[GAP_MSB:0] == 5'h0c) ##1 (!tx_gap_start_i)[*6];
    endsequence

    AST_MODE_RESET: assert property ($past(!reset_n_i) |-> mode_q == 16'h0001)
        else $error("mode register not 0001h after reset");

    AST_GBIT_ONE: assert property (mode_q[MODE_GBIT_BIT] && mode_q[15:4] == 12'h000)
        else $error("gigabit indicator or reserved mode bits wrong");

    AST_FEATURE_LOCK: assert property (seq_locked_feature_write |=> $stable(feature_q))
        else $error("feature register changed while MAC enabled");

    AST_LIMIT_LOCK: assert property ((host_req_i.wr && sel_limit_w && mode_q[MODE_RX_EN_BIT])
        |=> $stable(limit_q))
        else $error("length limit changed while MAC enabled");

    AST_PAUSE_SEND: assert property ((pause_send_request_i && mode_q[MODE_FLOW_BIT])
        |=> tx_pause_send_o && tx_pause_quanta_o == $past(pause_send_quanta_i))
        else $error("pause send request not forwarded");

    AST_PAUSE_GATED: assert property (!$past(mode_q[MODE_FLOW_BIT]) |-> !tx_pause_send_o)
        else $error("pause sent with flow control off");

    AST_PAUSE_HOLD: assert property ((rx_pause_rcvd_i && feature_q[FEAT_PAUSE_BIT])
        |=> tx_pause_hold_o && tx_hold_quanta_o == $past(rx_pause_quanta_i))
        else $error("received pause not reported");

    AST_LONG_FRAME: assert property (rx_frame_end_i
        |=> rx_long_frame_o == ($past(rx_frame_bytes_i) > $past(limit_q)))
        else $error("long frame flag wrong");

    AST_RUNT: assert property ((rx_frame_end_i && rx_frame_bytes_i == 16'h003f
        && !feature_q[FEAT_RUNT_BIT]) |=> rx_runt_drop_o)
        else $error("63 byte frame not dropped");

    AST_PROMISC: assert property (feature_q[FEAT_PRMS_BIT] |=> rx_addr_accept_o)
        else $error("promiscuous frame rejected");

    AST_MCAST_OFF: assert property ((rx_addr_i.multicast && !rx_addr_i.broadcast
        && !rx_addr_i.pause && !rx_addr_i.unicast_match
        && feature_q[FEAT_PRMS_BIT:FEAT_PRMS_BIT] == 1'b0
        && !feature_q[FEAT_MCAST_BIT]) |=> !rx_addr_accept_o)
        else $error("multicast accepted while disabled");

    AST_PAD_TYPE: assert property (rx_strip_pad_o |-> $past(rx_len_type_i) <= 16'h05dc)
        else $error("pad stripped from typed frame");

    AST_GAP_TIME: assert property (seq_gap12_run |=> tx_gap_done_o
        and $past(!tx_gap_done_o))
        else $error("12 byte gap not six word clocks");

endmodule : mac_config_registers

// File: mac_cfg_pkg.sv
package mac_cfg_pkg;

    localparam int HOST_ADDR_W = 8;
    localparam int HOST_DATA_W = 8;
    localparam int REG_W = 16;

    // Byte addresses of the low byte of each register
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_FEATURE = 8'h02;
    localparam logic [7:0] ADDR_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_GAP = 8'h08;

    localparam logic [15:0] MODE_RESET = 16'h0001;
    localparam logic [15:0] FEATURE_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_RESET = 16'h05ee;
    localparam logic [15:0] GAP_RESET = 16'h000c;

    // Writable bits; everything else holds its reset value
    localparam logic [15:0] MODE_WMASK = 16'h000e;
    localparam logic [15:0] FEATURE_WMASK = 16'h019f;
    localparam logic [15:0] LIMIT_WMASK = 16'hffff;
    localparam logic [15:0] GAP_WMASK = 16'h001f;

    localparam int MODE_TX_EN_BIT = 3;
    localparam int MODE_RX_EN_BIT = 2;
    localparam int MODE_FLOW_BIT = 1;
    localparam int MODE_GBIT_BIT = 0;
    localparam int FEAT_RUNT_BIT = 8;
    localparam int FEAT_BCAST_BIT = 7;
    localparam int FEAT_MCAST_BIT = 4;
    localparam int FEAT_PAUSE_BIT = 3;
    localparam int FEAT_NOFCS_BIT = 2;
    localparam int FEAT_STRIP_BIT = 1;
    localparam int FEAT_PRMS_BIT = 0;
    localparam int GAP_MSB = 4;

    localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
    localparam logic [15:0] MAX_LENGTH_FIELD = 16'h05dc;

    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic flow_control_enable;
        logic gigabit_indicator;
    } mode_s;

    typedef struct packed {
        logic accept_runt_frames;
        logic accept_broadcast;
        logic accept_multicast;
        logic honor_pause_frames;
        logic transmit_crc_suppress;
        logic strip_crc_and_pad;
        logic promiscuous_mode;
    } feature_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [HOST_ADDR_W-1:0] addr;
        logic [HOST_DATA_W-1:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic broadcast;
        logic multicast;
        logic pause;
        logic hash_hit;
        logic unicast_match;
    } rx_addr_s;

endpackage : mac_cfg_pkg

// File: cfg_word_reg.sv
`timescale 1ns/1ns
module cfg_word_reg #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WMASK = 16'hffff
) (
    input wire logic ref_clk_i, // Core clock
    input wire logic reset_n_i, // Synchronous reset, active low
    input wire logic wr_lo_i, // Write strobe, low byte
    input wire logic wr_hi_i, // Write strobe, high byte
    input wire logic [7:0] wdata_i, // Byte to write
    output logic [15:0] q_o // Register contents
);
    logic [15:0] word_r;
    logic [15:0] word_nxt;
    logic [15:0] lane_w;

    assign lane_w = {{8{wr_hi_i}}, {8{wr_lo_i}}} & WMASK;
    assign word_nxt = (word_r & ~lane_w) | ({wdata_i, wdata_i} & lane_w);
    assign q_o = word_r;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            word_r <= RESET_VAL;
        end else begin
            word_r <= word_nxt;
        end
    end

endmodule : cfg_word_reg

// File: host_model.sv
`timescale 1ns/1ns
module host_model (
    input wire logic ref_clk_i, // Core clock
    output mac_cfg_pkg::host_req_s host_req_o, // Byte access request
    input wire logic [mac_cfg_pkg::HOST_DATA_W-1:0] host_rdata_i, // Read byte
    input wire logic host_ack_i // Access done pulse
);
    import mac_cfg_pkg::*;

    initial host_req_o = '0;

    // Bits software may touch; the rest are written as zero and masked off on reads
    function automatic logic [15:0] defined_bits(input logic [7:0] base);
        case (base)
            ADDR_MODE: defined_bits = MODE_WMASK | 16'h0001;
            ADDR_FEATURE: defined_bits = FEATURE_WMASK;
            ADDR_GAP: defined_bits = GAP_WMASK;
            default: defined_bits = 16'hffff;
        endcase
    endfunction : defined_bits

    // One-cycle strobe; released address and data are inverted so stale values never look valid
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic ok);
        @(posedge ref_clk_i);
        host_req_o <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(posedge ref_clk_i);
        host_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        #1;
        ok = (host_ack_i === 1'b1);
        rdata = host_rdata_i;
        @(posedge ref_clk_i);
    endtask : access

    task automatic wr16(input logic [7:0] base, input logic [15:0] val);
        logic [7:0] unused;
        logic ok;
        logic [15:0] clean;
        clean = val & defined_bits(base);
        access(1'b1, base, clean[7:0], unused, ok);
        access(1'b1, base + 8'h01, clean[15:8], unused, ok);
    endtask : wr16

    task automatic rd16(input logic [7:0] base, output logic [15:0] val, output logic ok);
        logic ok_lo;
        access(1'b0, base, 8'h00, val[7:0], ok_lo);
        access(1'b0, base + 8'h01, 8'h00, val[15:8], ok);
        ok = ok & ok_lo;
        val = val & defined_bits(base);
    endtask : rd16
endmodule : host_model

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import mac_cfg_pkg::*;

    logic ref_clk_i, reset_n_i;
    logic tx_busy_i, rx_busy_i, pause_send_request_i, rx_pause_rcvd_i, rx_frame_end_i;
    logic tx_gap_start_i;
    logic [15:0] pause_send_quanta_i, rx_pause_quanta_i, rx_len_type_i, rx_frame_bytes_i;
    rx_addr_s rx_addr_i;
    host_req_s host_req;
    logic [7:0] host_rdata_o;
    mode_s mode_o;
    feature_s feature_o;
    logic [15:0] frame_length_limit_o, tx_pause_quanta_o, tx_hold_quanta_o;
    logic host_ack_o, tx_start_ok_o, rx_start_ok_o, mac_idle_o, tx_fcs_append_o;
    logic tx_pause_send_o, tx_pause_hold_o, rx_addr_accept_o, rx_strip_fcs_o, rx_strip_pad_o;
    logic rx_long_frame_o, rx_runt_drop_o, tx_gap_done_o;
    int failures, n_tests;

    mac_config_registers dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .host_req_i(host_req), .host_rdata_o(host_rdata_o), .host_ack_o(host_ack_o),
        .mode_o(mode_o), .feature_o(feature_o), .frame_length_limit_o(frame_length_limit_o),
        .tx_busy_i(tx_busy_i), .rx_busy_i(rx_busy_i), .tx_start_ok_o(tx_start_ok_o),
        .rx_start_ok_o(rx_start_ok_o), .mac_idle_o(mac_idle_o),
        .tx_fcs_append_o(tx_fcs_append_o), .pause_send_request_i(pause_send_request_i),
        .pause_send_quanta_i(pause_send_quanta_i), .tx_pause_send_o(tx_pause_send_o),
        .tx_pause_quanta_o(tx_pause_quanta_o), .rx_pause_rcvd_i(rx_pause_rcvd_i),
        .rx_pause_quanta_i(rx_pause_quanta_i), .tx_pause_hold_o(tx_pause_hold_o),
        .tx_hold_quanta_o(tx_hold_quanta_o), .rx_addr_i(rx_addr_i),
        .rx_addr_accept_o(rx_addr_accept_o), .rx_len_type_i(rx_len_type_i),
        .rx_strip_fcs_o(rx_strip_fcs_o), .rx_strip_pad_o(rx_strip_pad_o),
        .rx_frame_end_i(rx_frame_end_i), .rx_frame_bytes_i(rx_frame_bytes_i),
        .rx_long_frame_o(rx_long_frame_o), .rx_runt_drop_o(rx_runt_drop_o),
        .tx_gap_start_i(tx_gap_start_i), .tx_gap_done_o(tx_gap_done_o));

    host_model host (.ref_clk_i(ref_clk_i), .host_req_o(host_req),
        .host_rdata_i(host_rdata_o), .host_ack_i(host_ack_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic rd(input string name, input logic [7:0] base, input logic [15:0] exp);
        logic [15:0] v;
        logic ok;
        host.rd16(base, v, ok);
        chk(name, exp, v);
        chk({name, " ack"}, 16'h0001, 16'(ok));
    endtask : rd

    task automatic frame(input logic [15:0] bytes, input logic exp_long, input logic exp_runt);
        @(posedge ref_clk_i);
        rx_frame_end_i <= 1'b1;
        rx_frame_bytes_i <= bytes;
        @(posedge ref_clk_i);
        rx_frame_end_i <= 1'b0;
        rx_frame_bytes_i <= ~bytes;
        #1;
        chk("long frame", 16'(exp_long), 16'(rx_long_frame_o));
        chk("runt drop", 16'(exp_runt), 16'(rx_runt_drop_o));
    endtask : frame

    // Filter verdict: unicast, hash, pause, multicast, broadcast from bit 0 up
    function automatic logic exp_acc(input logic [15:0] f, input logic [4:0] a);
        return a[0] | f[0] | (a[4] & f[7]) | (a[3] & !a[4] & (a[2] | (f[4] & a[1])));
    endfunction : exp_acc

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        failures++;
        stop_test();
    end

    initial begin
        logic [15:0] feats [3];
        logic [15:0] ipg [2];
        logic [7:0] b;
        logic ok;
        logic on;
        feats = '{16'h0000, 16'h0090, 16'h0001};
        ipg = '{16'h000c, 16'h0005};
        {tx_busy_i, rx_busy_i, pause_send_request_i, rx_pause_rcvd_i} = '0;
        {rx_frame_end_i, tx_gap_start_i, rx_addr_i} = '0;
        {pause_send_quanta_i, rx_pause_quanta_i, rx_len_type_i, rx_frame_bytes_i} = '0;
        reset_n_i = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        #1;
        chk("gap done", 16'h0001, 16'(tx_gap_done_o));
        chk("fcs append", 16'h0001, 16'(tx_fcs_append_o));
        rd("mode", ADDR_MODE, 16'h0001);
        rd("feature", ADDR_FEATURE, 16'h0000);
        rd("limit", ADDR_LIMIT, 16'h05ee);
        rd("gap", ADDR_GAP, 16'h000c);
        rd("unmapped", 8'h06, 16'h0000);
        host.wr16(ADDR_MODE, 16'h0000);
        rd("mode gbit", ADDR_MODE, 16'h0001);
        host.wr16(ADDR_FEATURE, 16'h019f);
        rd("feature", ADDR_FEATURE, 16'h019f);
        chk("feature out", 16'h007f, 16'(feature_o));
        chk("fcs append", 16'h0000, 16'(tx_fcs_append_o));
        chk("strip fcs", 16'h0001, 16'(rx_strip_fcs_o));
        host.access(1'b1, ADDR_LIMIT + 8'h01, 8'h00, b, ok);
        rd("limit low byte", ADDR_LIMIT, 16'h00ee);
        // Locked writes below are deliberate; the lock must hold the old values
        host.wr16(ADDR_MODE, 16'h0008);
        chk("tx start", 16'h0001, 16'(tx_start_ok_o));
        chk("rx start", 16'h0000, 16'(rx_start_ok_o));
        chk("mode out", 16'h0009, 16'(mode_o));
        host.wr16(ADDR_FEATURE, 16'h0000);
        rd("feature locked", ADDR_FEATURE, 16'h019f);
        host.wr16(ADDR_MODE, 16'h0004);
        chk("rx start", 16'h0001, 16'(rx_start_ok_o));
        chk("tx start", 16'h0000, 16'(tx_start_ok_o));
        host.wr16(ADDR_LIMIT, 16'h0040);
        rd("limit locked", ADDR_LIMIT, 16'h00ee);
        host.wr16(ADDR_MODE, 16'h0000);
        tx_busy_i <= 1'b1;
        host.wr16(ADDR_GAP, 16'h0005);
        chk("idle", 16'h0000, 16'(mac_idle_o));
        rd("gap locked", ADDR_GAP, 16'h000c);
        {tx_busy_i, rx_busy_i} <= 2'h1;
        host.wr16(ADDR_LIMIT, 16'h0040);
        chk("idle rx", 16'h0000, 16'(mac_idle_o));
        rd("limit rx busy", ADDR_LIMIT, 16'h00ee);
        rx_busy_i <= 1'b0;
        host.wr16(ADDR_LIMIT, 16'h0040);
        chk("idle", 16'h0001, 16'(mac_idle_o));
        chk("limit out", 16'h0040, frame_length_limit_o);
        frame(16'h0041, 1'b1, 1'b0);
        frame(16'h0040, 1'b0, 1'b0);
        frame(16'h003f, 1'b0, 1'b0);
        host.wr16(ADDR_FEATURE, 16'h0000);
        frame(16'h003f, 1'b0, 1'b1);
        frame(16'h0040, 1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            on = (i == 1);
            host.wr16(ADDR_MODE, on ? 16'h0002 : 16'h0000);
            host.wr16(ADDR_FEATURE, on ? 16'h0008 : 16'h0000);
            @(posedge ref_clk_i);
            {pause_send_request_i, rx_pause_rcvd_i} <= 2'h3;
            pause_send_quanta_i <= 16'h1234;
            rx_pause_quanta_i <= 16'h0abc;
            @(posedge ref_clk_i);
            {pause_send_request_i, rx_pause_rcvd_i} <= 2'h0;
            #1;
            chk("pause send", 16'(on), 16'(tx_pause_send_o));
            chk("pause hold", 16'(on), 16'(tx_pause_hold_o));
            if (on) chk("send quanta", 16'h1234, tx_pause_quanta_o);
            if (on) chk("hold quanta", 16'h0abc, tx_hold_quanta_o);
            @(posedge ref_clk_i);
            #1;
            chk("pause send end", 16'h0000, 16'(tx_pause_send_o));
        end
        foreach (feats[k]) begin
            host.wr16(ADDR_FEATURE, feats[k]);
            for (int a = 0; a < 32; a++) begin
                @(posedge ref_clk_i);
                rx_addr_i <= 5'(a);
                @(posedge ref_clk_i);
                #1;
                chk("accept", 16'(exp_acc(feats[k], 5'(a))), 16'(rx_addr_accept_o));
            end
        end
        host.wr16(ADDR_FEATURE, 16'h0002);
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk_i);
            rx_len_type_i <= 16'h05dc + 16'(i);
            @(posedge ref_clk_i);
            #1;
            chk("strip pad", 16'(i == 0), 16'(rx_strip_pad_o));
        end
        foreach (ipg[k]) begin
            host.wr16(ADDR_GAP, ipg[k]);
            @(posedge ref_clk_i);
            tx_gap_start_i <= 1'b1;
            @(posedge ref_clk_i);
            tx_gap_start_i <= 1'b0;
            repeat ((ipg[k] + 16'h0001) >> 1) begin
                #1;
                chk("gap busy", 16'h0000, 16'(tx_gap_done_o));
                @(posedge ref_clk_i);
            end
            #1;
            chk("gap done", 16'h0001, 16'(tx_gap_done_o));
        end
        stop_test();
    end
endmodule : tb_top
